// *** supervisor_wakeup_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "wkc_consts.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module supervisor_wakeup_control_tb;
  import wkc_pkg::*;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic [3:0] b;
    logic [31:0] e;
  } swc_row_t;
  // shortened slow settle and hold-off so the run stays brief
  localparam int SLOW = 300;
  localparam int FAST = `WKC_FAST_CYC;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic sleep_req_i = 1'b0;
  logic [2:0] sleep_mode_i = 3'h0;
  logic wake_irq_i = 1'b0;
  logic soft_reset_i = 1'b0;
  logic mclk_from_osc_i = 1'b1;
  logic subsystem_clock_from_osc_i = 1'b1;
  logic [4:0] osc_mhz_i = 5'h05;
  logic cpu_hold_o, sleep_o, subsystem_clock_run_o, osc_overshoot_o;
  logic mclk_overspeed_o, subsystem_clock_overspeed_o, low_settle_o, high_settle_o;
  logic irq_o;
  logic [2:0] main_clock_divider_o;
  wkc_sup_t low_sup_state_o, low_mon_state_o;
  wkc_sup_t high_sup_state_o, high_mon_state_o;
  int failures = 0;
  int checks = 0;
  int n;
  logic [31:0] q;
  swc_row_t rows [20] = '{
    '{0, `WKC_ADR_LCTL, 0, 4'hF, 32'h0000_0009},
    '{0, `WKC_ADR_HCTL, 0, 4'hF, 32'h0000_0009},
    '{0, `WKC_ADR_CLK, 0, 4'hF, 0}, '{0, `WKC_ADR_STAT, 0, 4'hF, 0},
    '{0, `WKC_ADR_IEN, 0, 4'hF, 0}, '{0, `WKC_ADR_CLR, 0, 4'hF, 0},
    '{0, `WKC_ADR_LIVE, 0, 4'hF, 0},
    '{1, `WKC_ADR_STAT, 32'h0000_000F, 4'hF, 0},
    '{0, `WKC_ADR_STAT, 0, 4'hF, 0},
    '{1, 8'h1C, 32'h0000_0005, 4'hF, 0}, '{0, 8'h1C, 0, 4'hF, 0},
    '{1, `WKC_ADR_IEN, 32'h0000_000F, 4'h0, 0},
    '{0, `WKC_ADR_IEN, 0, 4'hF, 0},
    '{1, `WKC_ADR_IEN, 32'h0000_0005, 4'hF, 0},
    '{0, `WKC_ADR_IEN, 0, 4'hF, 32'h0000_0005},
    '{1, `WKC_ADR_CLK, 32'h0000_003F, 4'hF, 0},
    '{0, `WKC_ADR_CLK, 0, 4'hF, 32'h0000_003F},
    '{1, `WKC_ADR_CLK, 0, 4'hF, 0}, '{0, `WKC_ADR_CLK, 0, 4'hF, 0},
    '{0, `WKC_ADR_LIVE, 0, 4'hF, 0}};

  wkc_supervisor #(.SLOW_CYC(16'(SLOW))) i_wkc_supervisor (.clk_i, .nrst_i,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .sleep_req_i,
    .sleep_mode_i, .wake_irq_i, .soft_reset_i, .mclk_from_osc_i,
    .subsystem_clock_from_osc_i, .osc_mhz_i, .cpu_hold_o, .sleep_o,
    .main_clock_divider_o, .subsystem_clock_run_o, .osc_overshoot_o,
    .mclk_overspeed_o, .subsystem_clock_overspeed_o, .low_settle_o, .high_settle_o,
    .low_sup_state_o, .low_mon_state_o, .high_sup_state_o,
    .high_mon_state_o, .irq_o);

  always #5 clk_i = ~clk_i;

  task automatic test_done();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done

  // request held until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] b,
                     output logic [31:0] r);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= b;
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    r = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus

  function automatic logic sig(input int w);
    case (w)
      0: return low_settle_o;
      1: return high_settle_o;
      default: return cpu_hold_o;
    endcase
  endfunction : sig

  // cycles for which the chosen flag stays high
  task automatic count_hi(input int w, output int c);
    int k;
    k = 0;
    c = 0;
    while (sig(w) !== 1'b1 && k < 100) begin
      @(posedge clk_i);
      k++;
    end
    while (sig(w) === 1'b1 && c < 20000) begin
      @(posedge clk_i);
      c++;
    end
  endtask : count_hi

  task automatic go_sleep(input logic [2:0] m);
    @(posedge clk_i);
    sleep_req_i <= 1'b1;
    sleep_mode_i <= m;
    @(posedge clk_i);
    sleep_req_i <= 1'b0;
    @(posedge clk_i);
  endtask : go_sleep

  task automatic pulse_wake(input int which);
    @(posedge clk_i);
    if (which == 0) wake_irq_i <= 1'b1;
    else soft_reset_i <= 1'b1;
    @(posedge clk_i);
    wake_irq_i <= 1'b0;
    soft_reset_i <= 1'b0;
  endtask : pulse_wake

  initial begin
    repeat (30000) @(posedge clk_i);
    failures++;
    test_done();
  end

  initial begin
    repeat (20) @(posedge clk_i);
    `CHK("waitrequest idle", 1'b1, avs_waitrequest_o)
    `CHK("low sup reset", SUP_NORMAL, low_sup_state_o)
    `CHK("subsystem_clock run reset", 1'b1, subsystem_clock_run_o)
    nrst_i <= 1'b1;
    foreach (rows[i]) begin
      bus(rows[i].w, rows[i].a, rows[i].d, rows[i].b, q);
      if (!rows[i].w) `CHK("register row", rows[i].e, q)
    end
    // normal low side: long settle, done event raises the interrupt
    bus(1, `WKC_ADR_LCTL, 32'h0000_0009, 4'hF, q);
    count_hi(0, n);
    `CHK("low settle normal", SLOW, n)
    repeat (2) @(posedge clk_i);
    `CHK("irq settle done", 1'b1, irq_o)
    bus(1, `WKC_ADR_CLR, 32'h0000_000F, 4'hF, q);
    bus(0, `WKC_ADR_STAT, 0, 4'hF, q);
    `CHK("status cleared", 32'h0000_0000, q)
    `CHK("irq cleared", 1'b0, irq_o)
    // slow wake from the deepest mode, even when woken at once
    go_sleep(`WKC_SLEEP_LEVEL_FOUR);
    `CHK("sleep entered", 1'b1, sleep_o)
    `CHK("low sup in sleep", SUP_OFF, low_sup_state_o)
    `CHK("low mon in sleep", SUP_NORMAL, low_mon_state_o)
    `CHK("high sup in sleep", SUP_OFF, high_sup_state_o)
    `CHK("subsystem_clock gated in sleep", 1'b0, subsystem_clock_run_o)
    pulse_wake(0);
    count_hi(2, n);
    `CHK("slow hold", SLOW + 1, n)
    repeat (2) @(posedge clk_i);
    `CHK("irq wake done", 1'b1, irq_o)
    bus(1, `WKC_ADR_CLR, 32'h0000_000F, 4'hF, q);
    // fast configuration with a safe high side
    bus(1, `WKC_ADR_HCTL, 32'h0000_000D, 4'hF, q);
    count_hi(1, n);
    bus(1, `WKC_ADR_LCTL, 32'h0000_001B, 4'hF, q);
    count_hi(0, n);
    `CHK("low settle full", FAST, n)
    go_sleep(`WKC_SLEEP_LEVEL_THREE);
    pulse_wake(0);
    count_hi(2, n);
    `CHK("fast hold", FAST + 1, n)
    repeat (2) @(posedge clk_i);
    `CHK("osc overshoot", 1'b1, osc_overshoot_o)
    `CHK("main overspeed", 1'b1, mclk_overspeed_o)
    `CHK("sub overspeed", 1'b1, subsystem_clock_overspeed_o)
    repeat (600) @(posedge clk_i);
    `CHK("overshoot over", 1'b0, osc_overshoot_o)
    bus(1, `WKC_ADR_CLK, 32'h0000_0001, 4'hF, q);
    @(posedge clk_i);
    `CHK("divider by two", 3'h1, main_clock_divider_o)
    go_sleep(`WKC_SLEEP_LEVEL_THREE);
    pulse_wake(0);
    count_hi(2, n);
    repeat (2) @(posedge clk_i);
    `CHK("divided no overspeed", 1'b0, mclk_overspeed_o)
    repeat (30) @(posedge clk_i);
    bus(1, `WKC_ADR_CLK, 0, 4'hF, q);
    bus(1, `WKC_ADR_CLR, 32'h0000_000F, 4'hF, q);
    // entry while a settle is still running loses the wake
    bus(1, `WKC_ADR_LCTL, 32'h0000_001B, 4'hF, q);
    go_sleep(`WKC_SLEEP_LEVEL_FOUR);
    pulse_wake(0);
    repeat (3) @(posedge clk_i);
    `CHK("stuck on busy settle", 1'b1, sleep_o)
    pulse_wake(1);
    repeat (2) @(posedge clk_i);
    `CHK("soft reset recovers", 1'b0, sleep_o)
    count_hi(0, n);
    bus(1, `WKC_ADR_CLR, 32'h0000_000F, 4'hF, q);
    // fast low side with high side dropping normal to off
    bus(1, `WKC_ADR_HCTL, 32'h0000_0009, 4'hF, q);
    count_hi(1, n);
    go_sleep(`WKC_SLEEP_LEVEL_TWO);
    pulse_wake(0);
    repeat (3) @(posedge clk_i);
    `CHK("stuck sleep", 1'b1, sleep_o)
    `CHK("stuck no hold", 1'b0, cpu_hold_o)
    bus(0, `WKC_ADR_STAT, 0, 4'hF, q);
    `CHK("lost event", 1'b1, q[`WKC_EV_LOST])
    `CHK("lost masked", 1'b0, irq_o)
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    `CHK("reset leaves stuck", 1'b0, sleep_o)
    go_sleep(3'h5);
    `CHK("bad mode ignored", 1'b0, sleep_o)
    bus(0, `WKC_ADR_LCTL, 0, 4'hF, q);
    `CHK("low ctl after reset", 32'h0000_0009, q)
    // level raised while the low side is normal, request kept on
    bus(1, `WKC_ADR_CLK, 32'h0000_0038, 4'hF, q);
    bus(1, `WKC_ADR_LCTL, 32'h0000_0008, 4'hF, q);
    count_hi(0, n);
    subsystem_clock_from_osc_i <= 1'b0;
    go_sleep(`WKC_SLEEP_LEVEL_THREE);
    `CHK("off sup in sleep", SUP_OFF, low_sup_state_o)
    `CHK("high mon in sleep", SUP_NORMAL, high_mon_state_o)
    `CHK("subsystem_clock kept on", 1'b1, subsystem_clock_run_o)
    // risky settings, but the wake comes after the entry window
    repeat (100) @(posedge clk_i);
    pulse_wake(0);
    count_hi(2, n);
    `CHK("monitor slow hold", SLOW + 1, n)
    repeat (2) @(posedge clk_i);
    `CHK("level three limit", 1'b0, mclk_overspeed_o)
    `CHK("subsystem_clock not from osc", 1'b0, subsystem_clock_overspeed_o)
    test_done();
  end
endmodule : supervisor_wakeup_control_tb
`default_nettype wire

// *** wkc_consts.svh ***
`ifndef WKC_CONSTS_SVH
`define WKC_CONSTS_SVH

// register byte offsets
`define WKC_ADR_LCTL 8'h00
`define WKC_ADR_HCTL 8'h04
`define WKC_ADR_CLK 8'h08
`define WKC_ADR_STAT 8'h0C
`define WKC_ADR_CLR 8'h10
`define WKC_ADR_IEN 8'h14
`define WKC_ADR_LIVE 8'h18

// supervisor control field positions, same layout on both sides
`define WKC_SUP_EN 0
`define WKC_SUP_FP 1
`define WKC_SUP_MD 2
`define WKC_MON_EN 3
`define WKC_MON_FP 4
`define WKC_ACE 5
`define WKC_CTL_W 6
`define WKC_LCTL_RST 6'h09
`define WKC_HCTL_RST 6'h09

// clock control fields
`define WKC_DIV_MSB 2
`define WKC_DIV_LSB 0
`define WKC_REQ_EN 3
`define WKC_LVL_MSB 5
`define WKC_LVL_LSB 4
`define WKC_CLK_RST 6'h00
`define WKC_DIV_FULL 3'h0

// event bits of status, clear and enable
`define WKC_EV_LSET 0
`define WKC_EV_HSET 1
`define WKC_EV_WAKE 2
`define WKC_EV_LOST 3
`define WKC_EV_W 4
`define WKC_EV_RST 4'h0

// live status bits
`define WKC_LV_LSET 0
`define WKC_LV_HSET 1
`define WKC_LV_HOLD 2
`define WKC_LV_OVS 3
`define WKC_LV_SLEEP 4
`define WKC_LV_STUCK 5

// sleep mode codes
`define WKC_SLEEP_LEVEL_TWO 3'h2
`define WKC_SLEEP_LEVEL_THREE 3'h3
`define WKC_SLEEP_LEVEL_FOUR 3'h4

// overshoot limits per core level, MHz
`define WKC_MHZ_L0 5'h04
`define WKC_MHZ_L1 5'h07
`define WKC_MHZ_L2 5'h0B
`define WKC_MHZ_L3 5'h0E

// times in us and the clock in MHz
`define WKC_CLK_MHZ 100
`define WKC_T_SLOW_US 150
`define WKC_T_FAST_US 2
`define WKC_T_OVS_US 6
`define WKC_T_ENTRY_US 1
`define WKC_SLOW_CYC (`WKC_T_SLOW_US * `WKC_CLK_MHZ)
`define WKC_FAST_CYC (`WKC_T_FAST_US * `WKC_CLK_MHZ)
`define WKC_OVS_CYC (`WKC_T_OVS_US * `WKC_CLK_MHZ)
`define WKC_ENTRY_CYC (`WKC_T_ENTRY_US * `WKC_CLK_MHZ)

`endif

// *** wkc_pkg.sv ***
package wkc_pkg;
  typedef enum logic [1:0] {ST_ACTIVE, ST_SLEEP, ST_WAKE, ST_STUCK} wkc_state_t;
  typedef enum logic [1:0] {SUP_OFF, SUP_NORMAL, SUP_FULL} wkc_sup_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic busy;
    logic done;
  } wkc_tmr_t;

  typedef struct packed {
    wkc_state_t st;
    logic [5:0] lctl;
    logic [5:0] hctl;
    logic [5:0] clk;
    logic [3:0] status;
    logic [3:0] ien;
    logic irq;
    logic slow;
    logic deep34;
    logic hazard;
    logic hold;
    logic slp;
    logic subsystem_clock_run;
    logic mclk_ovs;
    logic subsystem_clock_ovs;
    wkc_sup_t lsup;
    wkc_sup_t lmon;
    wkc_sup_t hsup;
    wkc_sup_t hmon;
    logic waitreq;
    logic [31:0] rdata;
  } wkc_reg_t;
endpackage : wkc_pkg

// *** wkc_supervisor.sv ***
// Summary of operation
// R1: normal-performance low side holds off cpu 150 us after deep wake
// R2: low side off or full performance shortens the hold-off to 2 us
// R3: oscillator overshoots 6 us after wake from level three or four; flag main clock over level limit
// R4: software sets main clock divide-by-two before the deepest sleeps
// R5: software waits 32/48/80/100 cycles before restoring the divider
// R6: subsystem clock is not gated on wake and may overshoot 6 us
// R7: software may keep subsystem clock requested and halt its users
// R8: full-performance low side settles about 2 us after a write
// R9: normal low side settles about 150 us after a write
// R10: software uses normal mode when raising the core level
// R11: interrupt within 1 us of risky entry is lost; only reset recovers
// R12: software waits for both settle flags before deep sleep entry
// R13: risk when low side is fast and high side drops normal to off
// R14: sleep states: disabled off; auto turns off or drops full to normal
// R15: wake is slow when a low side unit stays normal in sleep
`timescale 1ns/1ps
`default_nettype none
`include "wkc_consts.svh"
module wkc_supervisor #(
  parameter logic [15:0] SLOW_CYC = 16'(`WKC_SLOW_CYC)
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic sleep_req_i,
  input wire logic [2:0] sleep_mode_i,
  input wire logic wake_irq_i,
  input wire logic soft_reset_i,
  input wire logic mclk_from_osc_i,
  input wire logic subsystem_clock_from_osc_i,
  input wire logic [4:0] osc_mhz_i,
  output logic cpu_hold_o,
  output logic sleep_o,
  output logic [2:0] main_clock_divider_o,
  output logic subsystem_clock_run_o,
  output logic osc_overshoot_o,
  output logic mclk_overspeed_o,
  output logic subsystem_clock_overspeed_o,
  output logic low_settle_o,
  output logic high_settle_o,
  output wkc_pkg::wkc_sup_t low_sup_state_o,
  output wkc_pkg::wkc_sup_t low_mon_state_o,
  output wkc_pkg::wkc_sup_t high_sup_state_o,
  output wkc_pkg::wkc_sup_t high_mon_state_o,
  output logic irq_o
);
  import wkc_pkg::*;

  localparam logic [15:0] FAST_CYC = 16'(`WKC_FAST_CYC);
  localparam logic [15:0] OVS_CYC = 16'(`WKC_OVS_CYC);
  localparam logic [15:0] ENTRY_CYC = 16'(`WKC_ENTRY_CYC);

  // unit state for the current power mode
  function automatic wkc_sup_t sup_state(input logic en, input logic fp,
      input logic md, input logic ace, input logic slp);
    wkc_sup_t s;
    s = SUP_OFF;
    if (en) begin
      if (!slp || (!ace && md)) begin
        s = fp ? SUP_FULL : SUP_NORMAL;
      end else if (ace && md && fp) begin
        s = SUP_NORMAL;
      end
    end
    return s;
  endfunction : sup_state

  function automatic logic [4:0] osc_limit(input logic [1:0] lvl);
    logic [4:0] m;
    case (lvl)
      2'h0: m = `WKC_MHZ_L0;
      2'h1: m = `WKC_MHZ_L1;
      2'h2: m = `WKC_MHZ_L2;
      default: m = `WKC_MHZ_L3;
    endcase
    return m;
  endfunction : osc_limit

  wkc_reg_t cur;
  wkc_reg_t nxt;

  logic hold_load, lset_load, hset_load, ovs_load, entry_load;
  logic [15:0] hold_cnt, lset_cnt, hset_cnt;
  logic hold_busy, hold_done, lset_busy, lset_done;
  logic hset_busy, hset_done, ovs_busy, entry_busy;
  logic [3:0] ev;
  logic [3:0] clr;
  logic [31:0] rmux;
  logic req, acc_wr, low_fast, high_risk, r15_slow, in_sleep;

  assign req = avs_read_i | avs_write_i;
  // a write lands only on the edge where waitrequest is seen low
  assign acc_wr = avs_write_i & !cur.waitreq & avs_byteenable_i[0];
  assign low_fast = !cur.lctl[`WKC_SUP_EN] | cur.lctl[`WKC_SUP_FP] |
                    !cur.lctl[`WKC_MON_EN] | cur.lctl[`WKC_MON_FP]; // R13
  assign high_risk = (cur.hctl[`WKC_SUP_EN] & !cur.hctl[`WKC_SUP_FP] &
                      (!cur.hctl[`WKC_SUP_MD] | cur.hctl[`WKC_ACE])) |
                     (cur.hctl[`WKC_MON_EN] & !cur.hctl[`WKC_MON_FP] &
                      cur.hctl[`WKC_ACE]); // R13
  assign r15_slow =
    (sup_state(cur.lctl[`WKC_SUP_EN], cur.lctl[`WKC_SUP_FP],
       cur.lctl[`WKC_SUP_MD], cur.lctl[`WKC_ACE], 1'b1) == SUP_NORMAL) ||
    (sup_state(cur.lctl[`WKC_MON_EN], cur.lctl[`WKC_MON_FP], 1'b1,
       cur.lctl[`WKC_ACE], 1'b1) == SUP_NORMAL); // R15

  always_comb begin
    case (avs_address_i)
      `WKC_ADR_LCTL: rmux = {26'h000_0000, cur.lctl};
      `WKC_ADR_HCTL: rmux = {26'h000_0000, cur.hctl};
      `WKC_ADR_CLK: rmux = {26'h000_0000, cur.clk};
      `WKC_ADR_STAT: rmux = {28'h000_0000, cur.status};
      `WKC_ADR_IEN: rmux = {28'h000_0000, cur.ien};
      `WKC_ADR_LIVE: rmux = {26'h000_0000, cur.st == ST_STUCK, cur.slp,
                             ovs_busy, cur.hold, hset_busy, lset_busy};
      default: rmux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    nxt = cur;
    hold_load = 1'b0;
    ovs_load = 1'b0;
    entry_load = 1'b0;
    ev = `WKC_EV_RST;
    ev[`WKC_EV_LSET] = lset_done;
    ev[`WKC_EV_HSET] = hset_done;
    clr = `WKC_EV_RST;
    lset_load = 1'b0;
    hset_load = 1'b0;
    // the settle window length follows the mode being written
    lset_cnt = avs_writedata_i[`WKC_SUP_FP] ? FAST_CYC : SLOW_CYC; // R8 R9
    hset_cnt = avs_writedata_i[`WKC_SUP_FP] ? FAST_CYC : SLOW_CYC;
    hold_cnt = cur.slow ? SLOW_CYC : FAST_CYC; // R1 R2

    nxt.waitreq = !(req && cur.waitreq);
    if (req && cur.waitreq) begin
      nxt.rdata = avs_read_i ? rmux : 32'h0000_0000;
    end
    if (acc_wr) begin
      case (avs_address_i)
        `WKC_ADR_LCTL: begin
          nxt.lctl = avs_writedata_i[`WKC_CTL_W-1:0];
          lset_load = 1'b1; // R8 R9
        end
        `WKC_ADR_HCTL: begin
          nxt.hctl = avs_writedata_i[`WKC_CTL_W-1:0];
          hset_load = 1'b1;
        end
        `WKC_ADR_CLK: nxt.clk = avs_writedata_i[`WKC_CTL_W-1:0];
        `WKC_ADR_CLR: clr = avs_writedata_i[`WKC_EV_W-1:0];
        `WKC_ADR_IEN: nxt.ien = avs_writedata_i[`WKC_EV_W-1:0];
        default: ;
      endcase
    end

    case (cur.st)
      ST_ACTIVE: begin
        if (sleep_req_i && (sleep_mode_i == `WKC_SLEEP_LEVEL_TWO ||
            sleep_mode_i == `WKC_SLEEP_LEVEL_THREE || sleep_mode_i == `WKC_SLEEP_LEVEL_FOUR)) begin
          nxt.st = ST_SLEEP;
          nxt.deep34 = (sleep_mode_i != `WKC_SLEEP_LEVEL_TWO);
          nxt.slow = r15_slow; // R15
          // entering before both settle windows close is risky too
          nxt.hazard = (low_fast & high_risk) | lset_busy | hset_busy;
          entry_load = 1'b1;
        end
      end
      ST_SLEEP: begin
        if (wake_irq_i) begin
          if (cur.hazard && entry_busy) begin
            nxt.st = ST_STUCK; // R11 R13
            ev[`WKC_EV_LOST] = 1'b1;
          end else begin
            nxt.st = ST_WAKE;
            nxt.hold = 1'b1; // R1 R2
            hold_load = 1'b1;
            ovs_load = cur.deep34; // R3 R6
          end
        end
      end
      ST_WAKE: begin
        if (hold_done) begin
          nxt.st = ST_ACTIVE;
          nxt.hold = 1'b0;
          ev[`WKC_EV_WAKE] = 1'b1;
        end
      end
      ST_STUCK: nxt.st = ST_STUCK; // R11
      default: nxt.st = ST_ACTIVE;
    endcase
    // a watchdog-class reset is the soft way out of a lost wake
    if (soft_reset_i) begin
      nxt.st = ST_ACTIVE; // R11
      nxt.hold = 1'b0;
    end

    // set wins over a clear in the same cycle
    nxt.status = (cur.status & ~clr) | ev;
    nxt.irq = |(nxt.status & nxt.ien);

    in_sleep = (nxt.st == ST_SLEEP) || (nxt.st == ST_STUCK);
    nxt.slp = in_sleep;
    nxt.lsup = sup_state(nxt.lctl[`WKC_SUP_EN], nxt.lctl[`WKC_SUP_FP],
      nxt.lctl[`WKC_SUP_MD], nxt.lctl[`WKC_ACE], in_sleep); // R14
    nxt.lmon = sup_state(nxt.lctl[`WKC_MON_EN], nxt.lctl[`WKC_MON_FP],
      1'b1, nxt.lctl[`WKC_ACE], in_sleep); // R14
    nxt.hsup = sup_state(nxt.hctl[`WKC_SUP_EN], nxt.hctl[`WKC_SUP_FP],
      nxt.hctl[`WKC_SUP_MD], nxt.hctl[`WKC_ACE], in_sleep); // R14
    nxt.hmon = sup_state(nxt.hctl[`WKC_MON_EN], nxt.hctl[`WKC_MON_FP],
      1'b1, nxt.hctl[`WKC_ACE], in_sleep); // R14
    // the subsystem clock is never masked on wake, only by sleep
    nxt.subsystem_clock_run = !in_sleep | nxt.clk[`WKC_REQ_EN]; // R6
    nxt.mclk_ovs = ovs_busy & !cur.hold & mclk_from_osc_i &
      (cur.clk[`WKC_DIV_MSB:`WKC_DIV_LSB] == `WKC_DIV_FULL) &
      (osc_mhz_i > osc_limit(cur.clk[`WKC_LVL_MSB:`WKC_LVL_LSB])); // R3
    nxt.subsystem_clock_ovs = ovs_busy & subsystem_clock_from_osc_i & cur.subsystem_clock_run; // R6
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cur <= '0;
      cur.lctl <= `WKC_LCTL_RST;
      cur.hctl <= `WKC_HCTL_RST;
      cur.clk <= `WKC_CLK_RST;
      cur.waitreq <= 1'b1;
      cur.lsup <= SUP_NORMAL;
      cur.lmon <= SUP_NORMAL;
      cur.hsup <= SUP_NORMAL;
      cur.hmon <= SUP_NORMAL;
      cur.subsystem_clock_run <= 1'b1;
    end else begin
      cur <= nxt;
    end
  end

  wkc_timer u_hold (.clk_i(clk_i), .nrst_i(nrst_i), .load_i(hold_load),
    .count_i(hold_cnt), .busy_o(hold_busy), .done_o(hold_done));
  wkc_timer u_lset (.clk_i(clk_i), .nrst_i(nrst_i), .load_i(lset_load),
    .count_i(lset_cnt), .busy_o(lset_busy), .done_o(lset_done));
  wkc_timer u_hset (.clk_i(clk_i), .nrst_i(nrst_i), .load_i(hset_load),
    .count_i(hset_cnt), .busy_o(hset_busy), .done_o(hset_done));
  wkc_timer u_ovs (.clk_i(clk_i), .nrst_i(nrst_i), .load_i(ovs_load),
    .count_i(OVS_CYC), .busy_o(ovs_busy), .done_o());
  wkc_timer u_entry (.clk_i(clk_i), .nrst_i(nrst_i), .load_i(entry_load),
    .count_i(ENTRY_CYC), .busy_o(entry_busy), .done_o());

  assign avs_readdata_o = cur.rdata;
  assign avs_waitrequest_o = cur.waitreq;
  assign cpu_hold_o = cur.hold;
  assign sleep_o = cur.slp;
  assign main_clock_divider_o = cur.clk[`WKC_DIV_MSB:`WKC_DIV_LSB];
  assign subsystem_clock_run_o = cur.subsystem_clock_run;
  assign osc_overshoot_o = ovs_busy;
  assign mclk_overspeed_o = cur.mclk_ovs;
  assign subsystem_clock_overspeed_o = cur.subsystem_clock_ovs;
  assign low_settle_o = lset_busy;
  assign high_settle_o = hset_busy;
  assign low_sup_state_o = cur.lsup;
  assign low_mon_state_o = cur.lmon;
  assign high_sup_state_o = cur.hsup;
  assign high_mon_state_o = cur.hmon;
  assign irq_o = cur.irq;

  // cycles the hold-off has lasted, for checking its length
  logic [15:0] hold_len_ff;
  always_ff @(posedge clk_i) begin
    if (!nrst_i || soft_reset_i) begin
      hold_len_ff <= 16'h0000;
    end else if (cpu_hold_o) begin
      hold_len_ff <= 16'(hold_len_ff + 16'h0001);
    end else begin
      hold_len_ff <= 16'h0000;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_wake_ok;
    cur.st == ST_SLEEP && wake_irq_i && !soft_reset_i &&
      !(cur.hazard && entry_busy);
  endsequence
  sequence s_wake_lost;
    cur.st == ST_SLEEP && wake_irq_i && !soft_reset_i &&
      cur.hazard && entry_busy;
  endsequence

  sequence s_entry;
    cur.st == ST_ACTIVE && sleep_req_i && !soft_reset_i &&
      (sleep_mode_i == `WKC_SLEEP_LEVEL_TWO || sleep_mode_i == `WKC_SLEEP_LEVEL_THREE ||
       sleep_mode_i == `WKC_SLEEP_LEVEL_FOUR);
  endsequence

  a_hold_start: assert property (s_wake_ok |=> cpu_hold_o) // R1
    else $error("hold-off did not start on wake");
  a_hold_length: assert property ($fell(cpu_hold_o) && // R2
      !$past(soft_reset_i) |-> hold_len_ff == 16'(hold_cnt + 16'h0001))
    else $error("hold-off length wrong for wake speed");
  a_overshoot_window: assert property (s_wake_ok and cur.deep34 // R6
      |=> osc_overshoot_o [*8])
    else $error("overshoot window not opened on deep wake");
  a_overspeed_cause: assert property (mclk_overspeed_o // R3
      |-> $past(osc_overshoot_o) && !$past(cpu_hold_o))
    else $error("main clock overspeed flagged outside window");
  a_settle_start: assert property (acc_wr && // R9
      avs_address_i == `WKC_ADR_LCTL |=> low_settle_o)
    else $error("low side settle flag not raised by write");
  a_wake_lost: assert property (s_wake_lost // R11
      |=> cur.st == ST_STUCK && !cpu_hold_o ##1 cur.st == ST_STUCK)
    else $error("risky early interrupt did not lose the wake");
  a_stuck_stays: assert property (cur.st == ST_STUCK && // R11
      !soft_reset_i |=> cur.st == ST_STUCK)
    else $error("lost wake recovered without reset");
  a_sleep_off: assert property (sleep_o && // R14
      !cur.lctl[`WKC_SUP_EN] |-> low_sup_state_o == SUP_OFF)
    else $error("disabled supervisor not off in sleep");
  a_bus_answer: assert property (req && avs_waitrequest_o
      |=> !avs_waitrequest_o)
    else $error("bus request not answered in one wait cycle");

  // outputs and the status register tied back to the settings and events that drive them
  a_sleep_entry: assert property (s_entry |=> sleep_o) // R14
    else $error("valid sleep request not taken");
  a_high_settle: assert property (acc_wr && // R9
      avs_address_i == `WKC_ADR_HCTL |=> high_settle_o)
    else $error("high side settle flag not raised by write");
  a_lost_flag: assert property (s_wake_lost // R11
      |=> cur.status[`WKC_EV_LOST])
    else $error("lost wake not recorded in status");
  a_subsystem_clock_gate: assert property (sleep_o && // R6
      !cur.clk[`WKC_REQ_EN] |-> !subsystem_clock_run_o)
    else $error("subsystem clock ran in sleep without request");
  a_awake_state: assert property (!sleep_o && // R14
      cur.lctl[`WKC_SUP_EN] |-> low_sup_state_o != SUP_OFF)
    else $error("enabled supervisor off while awake");
  a_overspeed_div: assert property (mclk_overspeed_o // R3
      |-> $past(main_clock_divider_o) == `WKC_DIV_FULL)
    else $error("main clock overspeed flagged while divided");
endmodule : wkc_supervisor
`default_nettype wire

// *** wkc_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
// one-shot down counter: busy for exactly count_i cycles after a load
module wkc_timer (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic load_i,
  input wire logic [15:0] count_i,
  output logic busy_o,
  output logic done_o
);
  import wkc_pkg::*;

  wkc_tmr_t cur;
  wkc_tmr_t nxt;

  always_comb begin
    nxt = cur;
    nxt.done = 1'b0;
    if (load_i) begin
      // a reload restarts the window, so back-to-back writes extend it
      nxt.cnt = 16'(count_i - 16'h0001);
      nxt.busy = (count_i != 16'h0000);
    end else if (cur.busy) begin
      if (cur.cnt == 16'h0000) begin
        nxt.busy = 1'b0;
        nxt.done = 1'b1;
      end else begin
        nxt.cnt = 16'(cur.cnt - 16'h0001);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  assign busy_o = cur.busy;
  assign done_o = cur.done;
endmodule : wkc_timer
`default_nettype wire
